// ---- dv/debug_component_model.sv ----
// Behavioural model of the debug components behind the decoder ports
`timescale 1ns/1ps
module debug_component_model
(
    input wire logic [debug_region_pkg::NUM_PORTS-1:0] comp_sel_in,
    input wire debug_region_pkg::bus_req_type comp_req_in,
    output logic [31:0] comp_rdata_out [debug_region_pkg::NUM_PORTS]
);
    import debug_region_pkg::*;
    // Unselected ports show the inverse, so a stale select cannot pass
    always_comb
    begin
        for (int i = 0; i < NUM_PORTS; i++)
        begin
            comp_rdata_out[i] = {4'hC, 4'(i), comp_req_in.addr[23:0]};
            if (!comp_sel_in[i])
            begin
                comp_rdata_out[i] = ~comp_rdata_out[i];
            end
        end
    end
endmodule

// ---- dv/debug_region_decoder_asserts.sv ----
// Port-level assertions for the debug region decoder
`timescale 1ns/1ps
module debug_region_decoder_asserts
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire debug_region_pkg::config_type config_in,
    input wire logic [31:0] addr_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [31:0] rdata_out,
    input wire logic core_halted_in,
    input wire logic [debug_region_pkg::NUM_PORTS-1:0] comp_sel_out,
    input wire debug_region_pkg::presence_type presence_out,
    input wire logic debug_state_out
);
    import debug_region_pkg::*;
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (rst_in);
    wire strobe = wr_in | rd_in;
    wire in_region = addr_in[31:20] == 12'hE00;
    wire tpu_win = addr_in[31:12] == TPU_BASE[31:12];
    wire itu_win = addr_in[31:12] == ITU_BASE[31:12];
    wire bpu_win = addr_in[31:12] == BPU_BASE[31:12];
    sequence s_read_outside;
        rd_in && !in_region;
    endsequence
    sequence s_idle;
        !rd_in;
    endsequence
    AST_OUTSIDE: assert property (strobe && !in_region |-> comp_sel_out == 8'h00)
        else $error("select outside the debug region");
    AST_OUTSIDE_READ: assert property (s_read_outside |=> rdata_out == 32'h0)
        else $error("read outside the region returned data");
    AST_IDLE_ZERO: assert property (s_idle |=> rdata_out == 32'h0)
        else $error("read data without a read");
    AST_ONEHOT: assert property ($onehot0(comp_sel_out) && (strobe || comp_sel_out == 8'h00))
        else $error("port select not one-hot or not gated");
    AST_ITU_WIN: assert property (strobe && itu_win && presence_out.itu |-> comp_sel_out == 8'h01)
        else $error("instrumentation window misrouted");
    AST_BPU_WIN: assert property (strobe && bpu_win && presence_out.bpu |-> comp_sel_out == 8'h04)
        else $error("breakpoint window misrouted");
    AST_TPU_SHARED: assert property (strobe && tpu_win
        && (!presence_out.tpu || config_in.trace_port_shared) |-> !comp_sel_out)
        else $error("absent trace port selected");
    AST_MONITOR: assert property (!$past(rst_in) |-> presence_out.monitor_exception == config_in.main_ext)
        else $error("monitor exception presence wrong");
    AST_WTU_TRACE: assert property (presence_out.wtu_trace
        |-> presence_out.itu && presence_out.wtu && presence_out.monitor_exception)
        else $error("watch trace without its prerequisites");
    AST_TPU_DEP: assert property (presence_out.tpu
        |-> presence_out.ptu || (presence_out.itu && presence_out.monitor_exception))
        else $error("trace port without a trace source");
    AST_DEBUG_STATE: assert property (presence_out.halting
        && $past(presence_out.halting) |-> debug_state_out == $past(core_halted_in))
        else $error("debug state does not follow halt");
endmodule
bind debug_ppb_region_decoder debug_region_decoder_asserts debug_region_decoder_asserts_i
(
    .clk_sys_in, .rst_in, .config_in, .addr_in, .wr_in, .rd_in, .rdata_out,
    .core_halted_in, .comp_sel_out, .presence_out, .debug_state_out
);

// ---- dv/tb_top.sv ----
// Self-checking bench for the debug region decoder
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
    import debug_region_pkg::*;
    typedef struct packed {config_type cfg; logic [31:0] addr; logic [3:0] port;
        logic [31:0] data;} row_type;
    localparam config_type C_MIN = '{1'b0, LEVEL_MINIMUM, 1'b0, 1'b0};
    localparam config_type C_MNM = '{1'b1, LEVEL_MINIMUM, 1'b0, 1'b0};
    localparam config_type C_BAS = '{1'b1, LEVEL_BASIC, 1'b1, 1'b0};
    localparam config_type C_BNM = '{1'b0, LEVEL_BASIC, 1'b0, 1'b0};
    localparam config_type C_CMP = '{1'b1, LEVEL_COMPREHENSIVE, 1'b1, 1'b1};
    localparam int NR = 19;
    // Port 8: no select; data is the decoder's own answer
    row_type rows [NR] = '{
        '{C_BAS, 32'hE0001010, 4'h1, 32'h0},
        '{C_BAS, 32'hE0002000, 4'h2, 32'h0},
        '{C_BAS, 32'hE0000000, 4'h8, 32'h0},
        '{C_BAS, 32'hE000ED00, 4'h3, 32'h0},
        '{C_BAS, 32'hE002ED04, 4'h3, 32'h0},
        '{C_BAS, 32'hE000ED48, 4'h8, 32'h00200000},
        '{C_BAS, 32'hE0041004, 4'h5, 32'h0},
        '{C_BAS, 32'hE0050000, 4'h6, 32'h0},
        '{C_BAS, 32'hF0000000, 4'h8, 32'h0},
        '{C_BAS, 32'hE00FF004, 4'h8, 32'hFFF02003},
        '{C_BAS, 32'hE00FF00C, 4'h8, 32'hFFF01002},
        '{C_BAS, 32'hE00FF018, 4'h8, 32'h0},
        '{C_CMP, 32'hE0000004, 4'h0, 32'h0},
        '{C_CMP, 32'hE0040000, 4'h8, 32'h0},
        '{C_CMP, 32'hE00FF010, 4'h8, 32'hFFF41002},
        '{C_MNM, 32'hE000EDF0, 4'h8, 32'h0},
        '{C_MNM, 32'hE000ED48, 4'h8, 32'h0},
        '{C_MIN, 32'hE000EDFC, 4'h8, 32'h0},
        '{C_MIN, 32'hE00FF000, 4'h8, 32'h0}
    };
    logic clk_sys_in, rst_in, wr_in, rd_in, core_halted_in;
    config_type config_in, cur;
    logic [31:0] addr_in, wdata_in, rdata_out, got, exp;
    logic [NUM_PORTS-1:0] comp_sel_out;
    logic [7:0] sel_seen, exp_sel;
    bus_req_type comp_req_out;
    logic [31:0] comp_rdata [NUM_PORTS];
    presence_type presence_out;
    logic debug_state_out, halt_request_out, debugger_enabled_out;
    int miscompares = 0;
    int samples_checked = 0;
    int cycles = 0;
    debug_ppb_region_decoder debug_ppb_region_decoder_i
    (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in), .config_in(config_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .core_halted_in(core_halted_in), .comp_sel_out(comp_sel_out),
        .comp_req_out(comp_req_out), .comp_rdata_in(comp_rdata), .presence_out(presence_out),
        .debug_state_out(debug_state_out), .halt_request_out(halt_request_out),
        .debugger_enabled_out(debugger_enabled_out)
    );
    debug_component_model debug_component_model_i
    (
        .comp_sel_in(comp_sel_out), .comp_req_in(comp_req_out), .comp_rdata_out(comp_rdata)
    );
    always #2.5 clk_sys_in = ~clk_sys_in;
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Whole run is under two hundred cycles; the ceiling leaves ample margin
    always @(posedge clk_sys_in)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            miscompares++;
            summarize();
        end
    end
    task automatic apply(input config_type c);
        @(posedge clk_sys_in);
        rst_in <= 1'b1;
        config_in <= c;
        repeat (10) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        repeat (2) @(posedge clk_sys_in);
        #1;
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        wr_in <= w;
        rd_in <= !w;
        addr_in <= a;
        wdata_in <= d;
        #1 sel_seen = comp_sel_out;
        `CHK(comp_req_out, {a, d, w, !w})
        @(posedge clk_sys_in);
        wr_in <= 1'b0;
        rd_in <= 1'b0;
        #1 got = rdata_out;
    endtask
    initial
    begin
        clk_sys_in = 1'b0;
        rst_in = 1'b1;
        {config_in, addr_in, wdata_in, wr_in, rd_in, core_halted_in} = '0;
        for (int i = 0; i < NR; i++)
        begin
            if (i == 0 || rows[i].cfg !== cur)
            begin
                cur = rows[i].cfg;
                apply(cur);
                `CHK(presence_out.monitor_exception, cur.main_ext)
            end
            bus(1'b0, rows[i].addr, 32'h0);
            exp_sel = rows[i].port < 4'h8 ? 8'h01 << rows[i].port : 8'h00;
            exp = rows[i].port < 4'h8 ? {4'hC, rows[i].port, rows[i].addr[23:0]} : rows[i].data;
            `CHK(sel_seen, exp_sel)
            `CHK(got, exp)
        end
        apply(C_BAS);
        `CHK(rdata_out, 32'h0)
        bus(1'b1, 32'hE000EDF0, 32'h3);
        `CHK(halt_request_out, 1'b1)
        `CHK(debugger_enabled_out, 1'b1)
        bus(1'b0, 32'hE002EDF0, 32'h0);
        `CHK(got & HALT_CTRL_WMASK, 32'h3)
        core_halted_in <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        #1 `CHK(debug_state_out, 1'b1)
        core_halted_in <= 1'b0;
        repeat (2) @(posedge clk_sys_in);
        #1 `CHK(debug_state_out, 1'b0)
        bus(1'b0, 32'hE000ED30, 32'h0);
        `CHK(got, 32'h1)
        bus(1'b1, 32'hE000ED30, 32'h1);
        bus(1'b0, 32'hE000ED30, 32'h0);
        `CHK(got, 32'h0)
        apply(C_BNM);
        `CHK(presence_out.wtu_trace, 1'b0)
        `CHK(presence_out.bpu, 1'b1)
        bus(1'b1, 32'hE000EDF0, 32'h1);
        bus(1'b0, 32'hE000EDF0, 32'h0);
        `CHK(got & HALT_CTRL_WMASK, 32'h1)
        apply(C_MIN);
        bus(1'b1, 32'hE000EDF0, 32'h3);
        `CHK(halt_request_out, 1'b0)
        apply(C_CMP);
        `CHK(presence_out.itu, 1'b1)
        `CHK(presence_out.wtu_trace, 1'b1)
        summarize();
    end
endmodule

// ---- rtl/debug_ppb_region_decoder.sv ----
// Debug region decoder: window routing, presence gating, ROM table
//
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/1ps

// Functional notes
// - All debug resources decode only inside the private peripheral bus region.
// - Each optional component outside the control space is one fixed 4KB window.
// - Instrumentation, watch and breakpoint units take the three lowest 4KB windows.
// - Secure control space window holds system and debug control block sub-ranges.
// - Non-secure control space alias reaches the same control block sub-ranges.
// - Trace port window routes locally only when unit is not shared, else reserved.
// - Program trace sits above trace port; range above is implementation defined.
// - ROM table in top 4KB lists which optional components are present.
// - Monitor debug exception exists exactly when the main extension exists.
// - Minimum with main: halting registers and fields zero; feature id zero.
// - Minimum without main: six debug registers zero; feature id zero.
// - Basic level provides access port, ROM table, breakpoint and watch units.
// - Basic with main implements halting registers; feature id reports support.
// - Basic without main implements handler, fault, halt, select, data, monitor.
// - Comprehensive needs main; adds instrumentation, watch trace and trace port.
// - Watch trace exists only with instrumentation, watch debug and main.
// - Trace port present only for instrumentation or program trace per extension.
// - Halted means debug state reported; not halted means non-debug state.
// - ROM entry bit 0 is one when component present, zero when absent; the trace port entry's bit 0 reads zero while the port is shared.
// - ROM component list ends with an all-zero entry.
module debug_ppb_region_decoder
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire debug_region_pkg::config_type config_in,
    input wire logic [31:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    input wire logic core_halted_in,
    output logic [debug_region_pkg::NUM_PORTS-1:0] comp_sel_out,
    output debug_region_pkg::bus_req_type comp_req_out,
    input wire logic [31:0] comp_rdata_in [debug_region_pkg::NUM_PORTS],
    output debug_region_pkg::presence_type presence_out,
    output logic debug_state_out,
    output logic halt_request_out,
    output logic debugger_enabled_out
);
    import debug_region_pkg::*;

    // ------------------------------------------------------------------
    // Configuration capture
    // ------------------------------------------------------------------
    // Straps are caught by a clocked process so reset holds only constants.
    config_type cfg;
    logic cfg_valid;

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            cfg <= '0;
            cfg_valid <= 1'b0;
        end
        else if (!cfg_valid)
        begin
            cfg <= config_in;
            cfg_valid <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Presence derivation
    // ------------------------------------------------------------------
    wire level_basic_up = (cfg.level != LEVEL_MINIMUM);
    // Comprehensive is meaningless without the main extension
    wire level_comp = (cfg.level == LEVEL_COMPREHENSIVE) && cfg.main_ext;
    wire pres_itu = level_comp;
    wire pres_wtu = level_basic_up;
    wire pres_wtu_trace = level_comp && pres_itu && pres_wtu;
    wire pres_ptu = cfg.program_trace && level_basic_up;
    wire pres_tpu = cfg.main_ext ? (pres_itu || pres_ptu)
        : pres_ptu;

    presence_type pres;

    assign pres.monitor_exception = cfg.main_ext;
    assign pres.halting = level_basic_up;

    assign pres.itu = pres_itu;
    assign pres.wtu = pres_wtu;
    assign pres.wtu_trace = pres_wtu_trace;
    assign pres.bpu = level_basic_up;
    assign pres.tpu = pres_tpu;
    assign pres.ptu = pres_ptu;
    assign pres.rom = level_basic_up;
    assign presence_out = pres;

    // ------------------------------------------------------------------
    // Window decode
    // ------------------------------------------------------------------
    wire [19:0] page = addr_in[31:12];
    wire [11:0] ofs = addr_in[11:0];

    wire in_region = (addr_in >= REGION_BASE)
        && (addr_in <= REGION_LAST);

    // Fixed windows: one page compare each
    wire hit_itu = in_region && (page == ITU_BASE[31:12]);
    wire hit_wtu = in_region && (page == WTU_BASE[31:12]);
    wire hit_bpu = in_region && (page == BPU_BASE[31:12]);

    wire hit_scs_s = in_region && (page == SCS_S_BASE[31:12]);
    wire hit_scs_ns = in_region && (page == SCS_NS_BASE[31:12]);

    wire hit_tpu = in_region && (page == TPU_BASE[31:12]);
    wire hit_ptu = in_region && (page == PTU_BASE[31:12]);
    // Spans many pages, so a range compare
    wire hit_impdef = (addr_in >= IMPDEF_BASE)
        && (addr_in <= IMPDEF_LAST);
    wire hit_rom = in_region && (page == ROM_BASE[31:12]);

    // Sub-ranges below are common to both aliases
    wire hit_scs = hit_scs_s || hit_scs_ns;
    wire in_scb = (ofs >= SCB_FIRST) && (ofs <= SCB_LAST);
    wire in_dcb = (ofs >= DCB_FIRST) && (ofs <= DCB_LAST);

    target_type target;

    always_comb
    begin
        if (hit_itu && pres.itu)
            target = TGT_ITU;
        else if (hit_wtu && pres.wtu)
            target = TGT_WTU;
        else if (hit_bpu && pres.bpu)
            target = TGT_BPU;
        else if (hit_scs_s)
            target = TGT_SCS_S;
        else if (hit_scs_ns)
            target = TGT_SCS_NS;
        else if (hit_tpu && pres.tpu && !cfg.trace_port_shared)
            target = TGT_TPU;
        else if (hit_ptu && pres.ptu)
            target = TGT_PTU;
        else if (hit_impdef)
            target = TGT_IMPDEF;
        else if (hit_rom && pres.rom)
            target = TGT_ROM;
        else
            target = TGT_NONE;
    end

    // Control space page minus its debug registers goes to an outside port
    // Three block-range registers are answered here
    wire local_scb_reg = (ofs == OFS_HANDLER_CTRL) || (ofs == OFS_FAULT_STATUS)
        || (ofs == OFS_FEATURE_ID);
    wire dcb_local = hit_scs && (in_dcb || local_scb_reg);

    // Port index per target; the control space is shared by both aliases
    logic [NUM_PORTS-1:0] sel;

    always_comb
    begin
        sel = '0;

        case (target)
            TGT_ITU: sel[0] = 1'b1;
            TGT_WTU: sel[1] = 1'b1;
            TGT_BPU: sel[2] = 1'b1;
            TGT_SCS_S, TGT_SCS_NS: sel[3] = !(in_scb && local_scb_reg) && !in_dcb;
            TGT_TPU: sel[4] = 1'b1;
            TGT_PTU: sel[5] = 1'b1;
            TGT_IMPDEF: sel[6] = 1'b1;
            TGT_ROM: sel[7] = 1'b0;
            default: sel = '0;
        endcase
    end

    assign comp_sel_out = sel & {NUM_PORTS{wr_in || rd_in}};
    assign comp_req_out.addr = addr_in;
    assign comp_req_out.wdata = wdata_in;
    assign comp_req_out.wr = wr_in;
    assign comp_req_out.rd = rd_in;

    // ------------------------------------------------------------------
    // Debug control block registers
    // ------------------------------------------------------------------
    // Halt control, select and data exist only with halting debug.
    logic [31:0] halt_ctrl;
    logic [31:0] reg_select;
    logic [31:0] reg_data;

    logic [31:0] monitor_ctrl;
    logic [31:0] fault_status;
    logic [31:0] handler_ctrl;

    wire dcb_wr = wr_in && dcb_local;
    wire wr_halt = dcb_wr && (ofs == OFS_HALT_CTRL)
        && pres.halting;
    wire wr_sel = dcb_wr && (ofs == OFS_REG_SELECT) && pres.halting;
    wire wr_data = dcb_wr && (ofs == OFS_REG_DATA) && pres.halting;

    // Monitor and fault always decoded; the masks drop fields absent at this level
    wire wr_mon = dcb_wr && (ofs == OFS_MONITOR_CTRL);
    wire wr_fault = dcb_wr && (ofs == OFS_FAULT_STATUS);
    wire wr_handler = dcb_wr && (ofs == OFS_HANDLER_CTRL) && pres.halting
        && !cfg.main_ext;

    // Writable masks per level: halting fields vanish at minimum level
    wire [31:0] mon_mask = (pres.halting ? MON_HALT_MASK : RESET_ZERO)
        | (pres.monitor_exception ? MON_MONITOR_MASK : RESET_ZERO);
    wire [31:0] fault_mask = (pres.halting ? FAULT_HALT_MASK : RESET_ZERO)
        | (pres.monitor_exception ? FAULT_MONITOR_MASK : RESET_ZERO);

    wire halted_bit = core_halted_in && pres.halting;

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            halt_ctrl <= RESET_ZERO;
            reg_select <= RESET_ZERO;
            reg_data <= RESET_ZERO;
            monitor_ctrl <= RESET_ZERO;
            handler_ctrl <= RESET_ZERO;
        end
        else
        begin
            if (wr_halt)
                halt_ctrl <= wdata_in & HALT_CTRL_WMASK;

            if (wr_sel)
                reg_select <= wdata_in;

            if (wr_data)
                reg_data <= wdata_in;

            if (wr_mon)
                monitor_ctrl <= wdata_in & mon_mask;

            if (wr_handler)
                handler_ctrl <= wdata_in & HANDLER_CTRL_MASK;
        end
    end

    // Fault status is write-one-to-clear; a halt event in the same cycle wins
    wire halt_event = halted_bit && !debug_state_out;
    wire [31:0] fault_set = {31'h0, halt_event} & FAULT_HALT_MASK;
    wire [31:0] fault_clr = wr_fault ? (wdata_in & fault_mask) : RESET_ZERO;
    wire [31:0] next_fault_status = (fault_status & ~fault_clr) | fault_set;

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
            fault_status <= RESET_ZERO;
        else
            fault_status <= next_fault_status;
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
            debug_state_out <= 1'b0;
        else
            debug_state_out <= halted_bit;
    end

    assign halt_request_out = halt_ctrl[HALT_BIT_DEBUGEN] && halt_ctrl[HALT_BIT_HALT];
    assign debugger_enabled_out = halt_ctrl[HALT_BIT_DEBUGEN];

    // Feature id reads zero at minimum level, basic support otherwise
    wire [31:0] feature_id = pres.halting ? FEATURE_ID_BASIC
        : RESET_ZERO;
    wire [31:0] halt_status = halt_ctrl
        | ({31'h0, debug_state_out} << HALT_BIT_STATUS);

    logic [31:0] dcb_rdata;

    always_comb
    begin
        if (ofs == OFS_HALT_CTRL)
            dcb_rdata = pres.halting ? halt_status : RESET_ZERO;
        else if (ofs == OFS_REG_SELECT)
            dcb_rdata = pres.halting ? reg_select : RESET_ZERO;
        else if (ofs == OFS_REG_DATA)
            dcb_rdata = pres.halting ? reg_data : RESET_ZERO;
        else if (ofs == OFS_MONITOR_CTRL)
            dcb_rdata = monitor_ctrl & mon_mask;
        else if (ofs == OFS_FAULT_STATUS)
            dcb_rdata = fault_status & fault_mask;
        else if (ofs == OFS_FEATURE_ID)
            dcb_rdata = feature_id;
        else if (ofs == OFS_HANDLER_CTRL)
            dcb_rdata = handler_ctrl;
        else
            dcb_rdata = RESET_ZERO;
    end

    // ------------------------------------------------------------------
    // ROM table
    // ------------------------------------------------------------------
    wire [31:0] ent_wtu = ROM_ENT_WTU | {31'h0, pres.wtu};
    wire [31:0] ent_bpu = ROM_ENT_BPU | {31'h0, pres.bpu};
    wire [31:0] ent_itu = ROM_ENT_ITU | {31'h0, pres.itu};

    wire tpu_local = pres.tpu && !cfg.trace_port_shared;
    wire [31:0] ent_tpu = ROM_ENT_TPU | {31'h0, tpu_local};
    wire [31:0] ent_ptu = ROM_ENT_PTU | {31'h0, pres.ptu};

    logic [31:0] rom_rdata;

    always_comb
    begin
        if (ofs == ROM_OFS_SCS)
            rom_rdata = ROM_ENT_SCS;
        else if (ofs == ROM_OFS_WTU)
            rom_rdata = ent_wtu;
        else if (ofs == ROM_OFS_BPU)
            rom_rdata = ent_bpu;
        else if (ofs == ROM_OFS_ITU)
            rom_rdata = ent_itu;
        else if (ofs == ROM_OFS_TPU)
            rom_rdata = ent_tpu;
        else if (ofs == ROM_OFS_PTU)
            rom_rdata = ent_ptu;
        else if (ofs == ROM_OFS_END)
            rom_rdata = ROM_END_MARK;
        else if (ofs == ROM_OFS_MEMTYPE)
            rom_rdata = ROM_MEMTYPE;
        else if (ofs == ROM_OFS_CID0)
            rom_rdata = ROM_CID0;
        else if (ofs == ROM_OFS_CID1)
            rom_rdata = ROM_CID1;
        else if (ofs == ROM_OFS_CID2)
            rom_rdata = ROM_CID2;
        else if (ofs == ROM_OFS_CID3)
            rom_rdata = ROM_CID3;
        else
            rom_rdata = RESET_ZERO;
    end

    // ------------------------------------------------------------------
    // Read return
    // ------------------------------------------------------------------
    // Local sources are sampled with the strobe; outside ports answer
    // combinationally so their word is captured in the same edge.
    logic [31:0] port_rdata;

    always_comb
    begin
        port_rdata = RESET_ZERO;

        for (int i = 0; i < NUM_PORTS; i++)
        begin
            if (sel[i])
                port_rdata = comp_rdata_in[i];
        end
    end

    wire [31:0] next_rdata = (target == TGT_ROM) ? rom_rdata
        : dcb_local ? dcb_rdata
        : port_rdata;

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
            rdata_out <= RESET_ZERO;
        else if (rd_in)
            rdata_out <= next_rdata;
        else
            rdata_out <= RESET_ZERO;
    end

endmodule

// ---- rtl/debug_region_pkg.sv ----
// Constants and carrier types for the debug region address decoder
package debug_region_pkg;

    // ------------------------------------------------------------------
    // Address windows
    // ------------------------------------------------------------------
    localparam logic [31:0] REGION_BASE = 32'hE000_0000;
    localparam logic [31:0] REGION_LAST = 32'hE00F_FFFF;
    localparam logic [31:0] ITU_BASE = 32'hE000_0000;
    localparam logic [31:0] WTU_BASE = 32'hE000_1000;
    localparam logic [31:0] BPU_BASE = 32'hE000_2000;
    localparam logic [31:0] SCS_S_BASE = 32'hE000_E000;
    localparam logic [31:0] SCS_NS_BASE = 32'hE002_E000;
    localparam logic [31:0] TPU_BASE = 32'hE004_0000;
    localparam logic [31:0] PTU_BASE = 32'hE004_1000;
    localparam logic [31:0] IMPDEF_BASE = 32'hE004_2000;
    localparam logic [31:0] IMPDEF_LAST = 32'hE00F_EFFF;
    localparam logic [31:0] ROM_BASE = 32'hE00F_F000;
    localparam logic [19:0] PAGE_MASK = 20'hFFFFF;
    localparam int PAGE_BITS = 12;

    // Sub-ranges inside a control space page (page offsets)
    localparam logic [11:0] SCB_FIRST = 12'hD00;
    localparam logic [11:0] SCB_LAST = 12'hD8F;
    localparam logic [11:0] DCB_FIRST = 12'hDF0;
    localparam logic [11:0] DCB_LAST = 12'hEFF;

    // Debug control block registers (page offsets)
    localparam logic [11:0] OFS_HANDLER_CTRL = 12'hD24;
    localparam logic [11:0] OFS_FAULT_STATUS = 12'hD30;
    localparam logic [11:0] OFS_FEATURE_ID = 12'hD48;
    localparam logic [11:0] OFS_HALT_CTRL = 12'hDF0;
    localparam logic [11:0] OFS_REG_SELECT = 12'hDF4;
    localparam logic [11:0] OFS_REG_DATA = 12'hDF8;
    localparam logic [11:0] OFS_MONITOR_CTRL = 12'hDFC;

    // Halting fields: halt control bits and monitor control halting bits
    localparam logic [31:0] HALT_CTRL_WMASK = 32'h0000_000F;
    localparam int HALT_BIT_DEBUGEN = 0;
    localparam int HALT_BIT_HALT = 1;
    localparam int HALT_BIT_STATUS = 17;
    localparam logic [31:0] MON_HALT_MASK = 32'h0000_07F1;
    localparam logic [31:0] MON_MONITOR_MASK = 32'h000F_0000;
    localparam logic [31:0] FAULT_HALT_MASK = 32'h0000_0001;
    localparam logic [31:0] FAULT_MONITOR_MASK = 32'h0000_001E;
    localparam logic [31:0] HANDLER_CTRL_MASK = 32'h0000_0FFF;
    localparam logic [31:0] FEATURE_ID_BASIC = 32'h0020_0000;
    localparam logic [31:0] RESET_ZERO = 32'h0000_0000;

    // ------------------------------------------------------------------
    // ROM table
    // ------------------------------------------------------------------
    localparam logic [11:0] ROM_OFS_SCS = 12'h000;
    localparam logic [11:0] ROM_OFS_WTU = 12'h004;
    localparam logic [11:0] ROM_OFS_BPU = 12'h008;
    localparam logic [11:0] ROM_OFS_ITU = 12'h00C;
    localparam logic [11:0] ROM_OFS_TPU = 12'h010;
    localparam logic [11:0] ROM_OFS_PTU = 12'h014;
    localparam logic [11:0] ROM_OFS_END = 12'h018;
    localparam logic [11:0] ROM_OFS_MEMTYPE = 12'hFCC;
    localparam logic [11:0] ROM_OFS_CID0 = 12'hFF0;
    localparam logic [11:0] ROM_OFS_CID1 = 12'hFF4;
    localparam logic [11:0] ROM_OFS_CID2 = 12'hFF8;
    localparam logic [11:0] ROM_OFS_CID3 = 12'hFFC;
    localparam logic [31:0] ROM_ENT_SCS = 32'hFFF0_F003;
    localparam logic [31:0] ROM_ENT_WTU = 32'hFFF0_2002;
    localparam logic [31:0] ROM_ENT_BPU = 32'hFFF0_3002;
    localparam logic [31:0] ROM_ENT_ITU = 32'hFFF0_1002;
    localparam logic [31:0] ROM_ENT_TPU = 32'hFFF4_1002;
    localparam logic [31:0] ROM_ENT_PTU = 32'hFFF4_2002;
    localparam logic [31:0] ROM_END_MARK = 32'h0000_0000;
    localparam logic [31:0] ROM_MEMTYPE = 32'h0000_0001;
    localparam logic [31:0] ROM_CID0 = 32'h0000_000D;
    localparam logic [31:0] ROM_CID1 = 32'h0000_0010;
    localparam logic [31:0] ROM_CID2 = 32'h0000_0005;
    localparam logic [31:0] ROM_CID3 = 32'h0000_00B1;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0]
    {
        LEVEL_MINIMUM = 2'b00,
        LEVEL_BASIC = 2'b01,
        LEVEL_COMPREHENSIVE = 2'b10
    } debug_level_type;

    // Build-time option set, sampled as straps
    typedef struct packed
    {
        logic main_ext;
        debug_level_type level;
        logic program_trace;
        logic trace_port_shared;
    } config_type;

    // Derived presence of each component
    typedef struct packed
    {
        logic monitor_exception;
        logic halting;
        logic itu;
        logic wtu;
        logic wtu_trace;
        logic bpu;
        logic tpu;
        logic ptu;
        logic rom;
    } presence_type;

    typedef enum logic [3:0]
    {
        TGT_NONE = 4'b0000,
        TGT_ITU = 4'b0001,
        TGT_WTU = 4'b0010,
        TGT_BPU = 4'b0011,
        TGT_SCS_S = 4'b0100,
        TGT_SCS_NS = 4'b0101,
        TGT_TPU = 4'b0110,
        TGT_PTU = 4'b0111,
        TGT_IMPDEF = 4'b1000,
        TGT_ROM = 4'b1001
    } target_type;

    localparam int NUM_PORTS = 8;

    typedef struct packed
    {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } bus_req_type;

endpackage
